// ---- verilog/entropy_pkg.sv ----
// Constants shared by the random byte generator: register map, fields, timing.
// Assumes a 125 MHz system clock and a byte-wide special function register bus.
`default_nettype none

package entropy_pkg;
    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] ADDR_ENTROPY_CONTROL  = 8'hD6;
    localparam logic [7:0] ADDR_ENTROPY_BYTE_OUT = 8'hD7;
    localparam logic [7:0] CONTROL_RESET         = 8'h40;
    localparam logic [7:0] BYTE_OUT_RESET        = 8'h00;
    localparam int         BIT_POWER_ON          = 7;
    localparam int         BIT_BIAS_FIX          = 6;
    localparam int         BIT_AVAILABLE         = 5;
    localparam int         BYTE_BITS             = 8;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_MHZ          = 125;
    localparam int STARTUP_US       = 250;
    localparam int STARTUP_CYCLES   = STARTUP_US * CLK_MHZ;
    localparam int BYTE_RAW_US      = 100;
    localparam int BYTE_RAW_CYCLES  = BYTE_RAW_US * CLK_MHZ;
    localparam int BIT_RAW_CYCLES   = BYTE_RAW_CYCLES / BYTE_BITS;
    localparam int DELAY_W          = 16;

    typedef enum logic [1:0] {
        GEN_OFF,
        GEN_START,
        GEN_RUN
    } gen_state_t;
endpackage

`default_nettype wire

// ---- verilog/entropy_gen.sv ----
// True random byte generator: noise bits, optional bias removal, byte packing.
// Bytes pass a one-entry stage into the data register, so one unread byte waits.
// Assumes sfr_* accesses are one-cycle strobes synchronous to clk and that the
// noise source presents one raw bit per noise_valid strobe.
// Byte timing is paced by counters; real noise makes the interval vary per byte.
`default_nettype none

module entropy_gen
    import entropy_pkg::*;
#(
    parameter int STARTUP_DELAY = STARTUP_CYCLES,
    parameter int BIT_DELAY     = BIT_RAW_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       core_standby,
    input  wire logic       noise_bit,
    input  wire logic       noise_valid,
    output logic            new_byte_interrupt
);
    // =====================================================================
    // Local constants
    // =====================================================================
    // Last bit index of the packer and the value the read bus shows when idle.
    localparam logic [2:0] LAST_BIT   = 3'(BYTE_BITS - 1);
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // =====================================================================
    // Control register
    // =====================================================================
    logic       generator_power_on_reg;
    logic       bias_fix_enable_reg;
    logic       byte_available_flag_reg;
    logic [7:0] entropy_byte_out_reg;
    logic [7:0] control_read;
    logic       ctl_wr;
    logic       dat_rd;
    logic       power_rise;

    // Strobe decode; writing one while already powered does not restart the wait.
    assign ctl_wr     = sfr_wr && (sfr_addr == ADDR_ENTROPY_CONTROL);
    assign dat_rd     = sfr_rd && (sfr_addr == ADDR_ENTROPY_BYTE_OUT);
    assign power_rise = ctl_wr && sfr_wdata[BIT_POWER_ON] && !generator_power_on_reg;

    // Only bits 7 and 6 are writable; the flag and low bits ignore writes.
    always_ff @(posedge clk) begin
        if (rst) begin
            generator_power_on_reg <= CONTROL_RESET[BIT_POWER_ON];
            bias_fix_enable_reg    <= CONTROL_RESET[BIT_BIAS_FIX];
        end else if (ctl_wr) begin
            generator_power_on_reg <= sfr_wdata[BIT_POWER_ON];
            bias_fix_enable_reg    <= sfr_wdata[BIT_BIAS_FIX];
        end
    end

    // Unused low bits always read as zero.
    always_comb begin
        control_read                = '0;
        control_read[BIT_POWER_ON]  = generator_power_on_reg;
        control_read[BIT_BIAS_FIX]  = bias_fix_enable_reg;
        control_read[BIT_AVAILABLE] = byte_available_flag_reg;
    end

    // Registered read data keeps the output straight off a flip-flop.
    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= RDATA_IDLE;
        end else if (sfr_rd && sfr_addr == ADDR_ENTROPY_CONTROL) begin
            sfr_rdata <= control_read;
        end else if (dat_rd) begin
            sfr_rdata <= entropy_byte_out_reg;
        end else begin
            sfr_rdata <= RDATA_IDLE;
        end
    end

    // =====================================================================
    // Sequencer: start-up delay then paced bit sampling
    // =====================================================================
    gen_state_t                         state_reg;
    logic [$clog2(STARTUP_DELAY+1)-1:0] wait_reg;
    logic [$clog2(BIT_DELAY+1)-1:0]     pace_reg;
    logic                               sample;

    // Standby is deliberately not consulted: the generator keeps running.
    always_ff @(posedge clk) begin
        if (rst || !generator_power_on_reg || power_rise) begin
            state_reg <= GEN_OFF;
            wait_reg  <= '0;
        end else begin
            case (state_reg)
                GEN_OFF: begin
                    state_reg <= GEN_START;
                    wait_reg  <= '0;
                end
                GEN_START: begin
                    wait_reg <= wait_reg + 1'b1;
                    if (wait_reg == ($bits(wait_reg))'(STARTUP_DELAY - 1)) begin
                        state_reg <= GEN_RUN;
                    end
                end
                GEN_RUN: state_reg <= GEN_RUN;
                default: state_reg <= GEN_OFF;
            endcase
        end
    end

    // Pacing sets the raw byte period; the corrector lengthens it by discards.
    always_ff @(posedge clk) begin
        if (rst || state_reg != GEN_RUN) begin
            pace_reg <= '0;
        end else if (pace_reg == ($bits(pace_reg))'(BIT_DELAY - 1)) begin
            pace_reg <= '0;
        end else begin
            pace_reg <= pace_reg + 1'b1;
        end
    end

    assign sample = (state_reg == GEN_RUN) && noise_valid &&
                    (pace_reg == ($bits(pace_reg))'(BIT_DELAY - 1));

    // =====================================================================
    // Bias corrector (von Neumann) and packer
    // =====================================================================
    logic       pair_half_reg;
    logic       pair_first_reg;
    logic       bit_ok;
    logic       bit_val;
    logic [7:0] shift_reg;
    logic [2:0] count_reg;
    logic       buf_valid_reg;
    logic [7:0] buf_data_reg;
    logic       buf_ready;

    // Pair tracking restarts whenever the corrector is off or the generator idles.
    always_ff @(posedge clk) begin
        if (rst || state_reg != GEN_RUN || !bias_fix_enable_reg) begin
            pair_half_reg  <= 1'b0;
            pair_first_reg <= 1'b0;
        end else if (sample) begin
            pair_half_reg  <= !pair_half_reg;
            pair_first_reg <= noise_bit;
        end
    end

    // Unequal pairs emit the first bit; equal pairs vanish.
    always_comb begin
        bit_val = bias_fix_enable_reg ? pair_first_reg : noise_bit;
        bit_ok  = sample && (!bias_fix_enable_reg ||
                  (pair_half_reg && (pair_first_reg != noise_bit)));
    end

    // A completed byte enters the buffer stage only while the stage is empty.
    assign buf_ready = !buf_valid_reg;

    // A full stage stalls the packer on its last bit; that bit is dropped, not kept.
    always_ff @(posedge clk) begin
        if (rst || state_reg != GEN_RUN) begin
            shift_reg <= '0;
            count_reg <= '0;
        end else if (bit_ok && !(count_reg == LAST_BIT && !buf_ready)) begin
            shift_reg <= {shift_reg[BYTE_BITS-2:0], bit_val};
            count_reg <= count_reg + 1'b1;
        end
    end

    // The stage empties into the data register as soon as the flag is clear.
    always_ff @(posedge clk) begin
        if (rst || power_rise) begin
            buf_valid_reg <= 1'b0;
            buf_data_reg  <= BYTE_OUT_RESET;
        end else if (bit_ok && count_reg == LAST_BIT && buf_ready) begin
            buf_valid_reg <= 1'b1;
            buf_data_reg  <= {shift_reg[BYTE_BITS-2:0], bit_val};
        end else if (buf_valid_reg && !byte_available_flag_reg) begin
            buf_valid_reg <= 1'b0;
        end
    end

    // =====================================================================
    // Data register, flag and interrupt
    // =====================================================================
    // A byte moves in only while the flag is clear, so a load and a read never collide.
    always_ff @(posedge clk) begin
        if (rst) begin
            entropy_byte_out_reg    <= BYTE_OUT_RESET;
            byte_available_flag_reg <= 1'b0;
        end else if (power_rise) begin
            entropy_byte_out_reg    <= BYTE_OUT_RESET;
            byte_available_flag_reg <= 1'b0;
        end else if (buf_valid_reg && !byte_available_flag_reg) begin
            entropy_byte_out_reg    <= buf_data_reg;
            byte_available_flag_reg <= 1'b1;
        end else if (dat_rd) begin
            byte_available_flag_reg <= 1'b0;
        end
    end

    // The interrupt copies the flag's next value so both move together.
    always_ff @(posedge clk) begin
        if (rst || power_rise) begin
            new_byte_interrupt <= 1'b0;
        end else if (buf_valid_reg && !byte_available_flag_reg) begin
            new_byte_interrupt <= 1'b1;
        end else if (dat_rd) begin
            new_byte_interrupt <= 1'b0;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    // Flag, interrupt and data register: flag and interrupt move together; the data register holds while the flag is set.
    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        new_byte_interrupt == byte_available_flag_reg)
        else $error("interrupt differs from flag");
    AST_IRQ_RISE_BYTE: assert property (@(posedge clk) disable iff (rst)
        $rose(new_byte_interrupt) |-> $past(buf_valid_reg))
        else $error("interrupt rose without a byte");
    AST_RISE_CLEARS: assert property (@(posedge clk) disable iff (rst)
        power_rise |=> !byte_available_flag_reg && entropy_byte_out_reg == BYTE_OUT_RESET)
        else $error("power-on edge did not clear");
    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (rst)
        dat_rd && byte_available_flag_reg && !power_rise |=> !byte_available_flag_reg)
        else $error("data read did not clear flag");
    AST_SET_ON_BYTE: assert property (@(posedge clk) disable iff (rst)
        buf_valid_reg && !byte_available_flag_reg && !power_rise |=> byte_available_flag_reg)
        else $error("flag not set on fresh byte");
    AST_DATA_HELD: assert property (@(posedge clk) disable iff (rst)
        byte_available_flag_reg && !power_rise |=>
            entropy_byte_out_reg == $past(entropy_byte_out_reg))
        else $error("data changed while flag set");
    // Register bus: read data is registered and quiet between reads.
    AST_DATA_READ: assert property (@(posedge clk) disable iff (rst)
        dat_rd |=> sfr_rdata == $past(entropy_byte_out_reg))
        else $error("data read returned wrong byte");
    AST_CTRL_READ: assert property (@(posedge clk) disable iff (rst)
        sfr_rd && sfr_addr == ADDR_ENTROPY_CONTROL |=> sfr_rdata[BIT_AVAILABLE-1:0] == '0)
        else $error("unused control bits read nonzero");
    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
        !sfr_rd |=> sfr_rdata == RDATA_IDLE)
        else $error("read bus not idle without a read");
    AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (rst)
        ctl_wr |=> bias_fix_enable_reg == $past(sfr_wdata[BIT_BIAS_FIX]))
        else $error("corrector enable not written");
    AST_POWER_WRITE: assert property (@(posedge clk) disable iff (rst)
        ctl_wr |=> generator_power_on_reg == $past(sfr_wdata[BIT_POWER_ON]))
        else $error("power bit not written");
    // Sequencer: no sampling before the start-up wait has run out.
    AST_NO_RUN_UNPOWERED: assert property (@(posedge clk) disable iff (rst)
        !generator_power_on_reg |=> state_reg != GEN_RUN)
        else $error("running while powered down");
    AST_STARTUP_WAIT: assert property (@(posedge clk) disable iff (rst)
        $rose(state_reg == GEN_RUN) |-> $past(wait_reg) ==
            ($bits(wait_reg))'(STARTUP_DELAY - 1))
        else $error("start-up delay wrong");
    AST_NO_EARLY_SAMPLE: assert property (@(posedge clk) disable iff (rst)
        state_reg != GEN_RUN |-> !sample)
        else $error("noise sampled before start-up ended");
    AST_STANDBY_RUNS: assert property (@(posedge clk) disable iff (rst)
        core_standby && state_reg == GEN_RUN && generator_power_on_reg && !ctl_wr |=>
            state_reg == GEN_RUN)
        else $error("generator stopped in standby");
    // Corrector and packer.
    AST_RAW_SHIFT: assert property (@(posedge clk) disable iff (rst)
        bit_ok && !bias_fix_enable_reg && count_reg != LAST_BIT |=>
            shift_reg[0] == $past(noise_bit))
        else $error("raw bit not shifted in");
    AST_STALL_HOLDS: assert property (@(posedge clk) disable iff (rst)
        bit_ok && count_reg == LAST_BIT && !buf_ready |=> count_reg == LAST_BIT)
        else $error("packer moved while stage full");
    AST_BUF_LOAD: assert property (@(posedge clk) disable iff (rst)
        bit_ok && count_reg == LAST_BIT && buf_ready && !power_rise |=> buf_valid_reg)
        else $error("completed byte not staged");
    AST_EQUAL_PAIR_DROPPED: assert property (@(posedge clk) disable iff (rst)
        sample && bias_fix_enable_reg && pair_half_reg &&
            pair_first_reg == noise_bit |-> !bit_ok)
        else $error("equal pair produced a bit");
    AST_FIRST_HALF_SILENT: assert property (@(posedge clk) disable iff (rst)
        sample && bias_fix_enable_reg && !pair_half_reg |-> !bit_ok)
        else $error("first half of pair produced a bit");

    // Main scenarios worth seeing at least once.
    COV_BYTE: cover property (@(posedge clk) $rose(byte_available_flag_reg));
    COV_READ: cover property (@(posedge clk) dat_rd && byte_available_flag_reg);
    COV_FIXED: cover property (@(posedge clk) bit_ok && bias_fix_enable_reg);
    COV_STALL: cover property (@(posedge clk) bit_ok && count_reg == LAST_BIT && !buf_ready);
    COV_STARTUP: cover property (@(posedge clk) $rose(state_reg == GEN_RUN));
endmodule

`default_nettype wire

// ---- testbench/noise_source_model.sv ----
// Behavioural noise source: one raw bit per valid strobe.
// Assumes the bench picks the pattern; the generator samples on its own timing.
`default_nettype none

module noise_source_model #(
    parameter int TOGGLE_CYCLES = 2
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] pattern,
    input  wire logic       enable,
    output logic            noise_bit,
    output logic            noise_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Pattern source
    // ==========================================================
    int   count;
    logic phase;

    // The phase flips every TOGGLE_CYCLES, so samples taken at that spacing always alternate.
    always_ff @(posedge clk) begin
        if (rst || count == TOGGLE_CYCLES - 1) begin
            count <= 0;
        end else begin
            count <= count + 1;
        end
        if (rst) begin
            phase <= 1'b0;
        end else if (count == TOGGLE_CYCLES - 1) begin
            phase <= ~phase;
        end
    end

    // Without a strobe the bit keeps moving, so a stale level is never mistaken for data.
    assign noise_valid = enable;
    assign noise_bit   = (enable && pattern != 2'h2) ? pattern[0] : phase;
endmodule

`default_nettype wire

// ---- testbench/true_random_byte_generator_tb_top.sv ----
// Self-checking bench for the random byte generator, driven over its register strobes.
// Assumes shortened start-up and bit timing parameters and the noise source model.
`default_nettype none

module true_random_byte_generator_tb_top import entropy_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int START_DLY = 20;
    localparam int BIT_DLY   = 2;
    logic       clk, rst, sfr_wr, sfr_rd, core_standby, noise_bit, noise_valid;
    logic       new_byte_interrupt, src_enable;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
    logic [1:0] src_pattern;
    int         bad_count, checks, cycles, n, raw_time, fix_time;

    entropy_gen #(.STARTUP_DELAY(START_DLY), .BIT_DELAY(BIT_DLY)) entropy_gen_inst (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .core_standby(core_standby),
        .noise_bit(noise_bit), .noise_valid(noise_valid),
        .new_byte_interrupt(new_byte_interrupt));
    noise_source_model #(.TOGGLE_CYCLES(BIT_DLY)) noise_source_model_inst (
        .clk(clk), .rst(rst), .pattern(src_pattern), .enable(src_enable),
        .noise_bit(noise_bit), .noise_valid(noise_valid));

    // ==========================================================
    // Clock, timeout and bus tasks
    // ==========================================================
    // The ceiling sits well above the few hundred cycles the tests need.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 3000) begin
                bad_count++;
                tally_and_finish();
            end
        end
    end

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        sfr_addr  = addr;
        sfr_wdata = data;
        sfr_wr    = 1'b1;
        @(posedge clk);
        #1;
        sfr_wr    = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the strobe edge.
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        #1;
        sfr_addr = addr;
        sfr_rd   = 1'b1;
        @(posedge clk);
        #1;
        sfr_rd   = 1'b0;
        data     = sfr_rdata;
    endtask

    // Either of two values is accepted where the pair phase of the noise is unknown.
    task automatic check(input logic [7:0] got, exp, alt, input string what);
        checks++;
        if (got !== exp && got !== alt) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic rd_check(input logic [7:0] addr, exp, alt, input string what);
        sfr_read(addr, v);
        check(v, exp, alt, what);
    endtask

    task automatic wait_irq(input int limit, output int cnt);
        cnt = 0;
        while (new_byte_interrupt !== 1'b1 && cnt < limit) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    // Power is dropped first so every start is a genuine off-to-on edge.
    // Data and flag are only used after this returns with power up again.
    task automatic power_on(input logic [7:0] ctl);
        sfr_write(ADDR_ENTROPY_CONTROL, 8'h00);
        sfr_write(ADDR_ENTROPY_CONTROL, ctl);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        {rst, sfr_wr, sfr_rd, core_standby, src_enable} = 5'b10001;
        {sfr_addr, sfr_wdata, src_pattern} = {8'h00, 8'h00, 2'h1};
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_check(ADDR_ENTROPY_CONTROL, 8'h40, 8'h40, "control reset");
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'h00, 8'h00, "data reset");
        rd_check(8'h00, 8'h00, 8'h00, "unmapped read");
        check({7'h00, new_byte_interrupt}, 8'h00, 8'h00, "irq at reset");
        sfr_write(ADDR_ENTROPY_CONTROL, 8'h3F);
        rd_check(ADDR_ENTROPY_CONTROL, 8'h00, 8'h00, "flag and unused bits");
        sfr_write(ADDR_ENTROPY_BYTE_OUT, 8'hAA);
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'h00, 8'h00, "data read-only");
        core_standby = 1'b1;
        power_on(8'h80);
        wait_irq(100, n);
        check({7'h00, n >= 34 && n <= 48}, 8'h01, 8'h01, "first byte delay");
        rd_check(ADDR_ENTROPY_CONTROL, 8'hA0, 8'hA0, "flag set");
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'hFF, 8'hFF, "raw ones");
        check({7'h00, new_byte_interrupt}, 8'h00, 8'h00, "irq clear on read");
        repeat (60) @(posedge clk);
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'hFF, 8'hFF, "stalled byte");
        wait_irq(6, n);
        check({7'h00, n < 6}, 8'h01, 8'h01, "queued byte sets flag again");
        power_on(8'h80);
        rd_check(ADDR_ENTROPY_CONTROL, 8'h80, 8'h80, "flag cleared at power-on");
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'h00, 8'h00, "data cleared at power-on");
        src_pattern = 2'h2;
        power_on(8'h80);
        wait_irq(100, raw_time);
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'h55, 8'hAA, "raw alternating");
        power_on(8'hC0);
        wait_irq(150, fix_time);
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'h00, 8'hFF, "corrected alternating");
        check({7'h00, fix_time > raw_time + 12}, 8'h01, 8'h01, "corrected slower");
        src_pattern = 2'h1;
        power_on(8'hC0);
        wait_irq(150, n);
        check({7'h00, n == 150}, 8'h01, 8'h01, "equal pairs discarded");
        src_enable = 1'b0;
        power_on(8'h80);
        wait_irq(100, n);
        check({7'h00, n == 100}, 8'h01, 8'h01, "no strobe no byte");
        src_enable = 1'b1;
        wait_irq(60, n);
        rd_check(ADDR_ENTROPY_BYTE_OUT, 8'hFF, 8'hFF, "strobed byte");
        tally_and_finish();
    end
endmodule

`default_nettype wire
